// [debug_access_unit.sv]
// Register address decoding and transaction routing of a debug access unit
`include "dbg_consts.svh"

// What this block does
// R1: Every transaction carries two word address bits
// R2: Link register chosen by bank and address
// R3: Port access routed by selector, word in bank
// R4: Port register address is bank above bits
// R5: Low two register address bits are zero
// R6: Selector and bank held across port accesses
// R7: Exactly one debug port, fixed kind
// R8: At least one access port, any kind
// R9: Scan port serves at most eight chains
// R10: Preferably one controller per scan chain
// R11: Ports identify; unknown ones can be skipped
// R12: All register transfers are 32 bits
// R13: Debugger writes select before port accesses
// R14: Serial request names target and address
// R15: Absent port completes with no side effects
module debug_access_unit #(
    parameter int PORT_COUNT = 1,
    parameter logic [31:0] ID_VALUE = 32'h0000_1001, // Arbitrary value
    parameter dbg_pkg::port_kind_t DEBUG_PORT_KIND = dbg_pkg::KIND_SCAN,
    parameter logic [3:0] SCAN_CHAINS = 4'h1,
    parameter logic [3:0] TAPS_PER_CHAIN = 4'h1
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic REQ_VALID,
    input wire logic REQ_PORT,
    input wire logic [1:0] REQ_ADDR,
    input wire logic REQ_WRITE,
    input wire logic [31:0] REQ_WDATA,
    output logic REQ_READY,
    output logic RESP_VALID,
    output logic RESP_FAULT,
    output logic [31:0] RESP_RDATA,
    output logic PORT_REQ,
    output logic [7:0] PORT_SEL,
    output logic [7:0] PORT_ADDR,
    output logic PORT_WRITE,
    output logic [31:0] PORT_WDATA,
    input wire logic [PORT_COUNT-1:0] PORT_ACK,
    input wire logic [PORT_COUNT*32-1:0] PORT_RDATA
);
    // At least one port is always built, even if the parameter says none
    localparam int PORTS = (PORT_COUNT < 1) ? 1 : PORT_COUNT; // R8

    // The chain count reported never exceeds the scan port's limit
    localparam logic [3:0] CHAINS =
        (SCAN_CHAINS > `MAX_SCAN_CHAINS) ? `MAX_SCAN_CHAINS : SCAN_CHAINS; // R9

    localparam dbg_pkg::core_state_t RST_STATE = '{
        state: dbg_pkg::ST_IDLE,
        ready: 1'b1,
        port_selector: `RST_BYTE,
        port_bank_field: `RST_NIBBLE,
        link_bank_field: `RST_NIBBLE,
        scratch: `RST_WORD,
        read_buffer: `RST_WORD,
        resp_valid: 1'b0,
        resp_fault: 1'b0,
        resp_rdata: `RST_WORD,
        port_req: 1'b0,
        port_sel: `RST_BYTE,
        port_addr: `RST_BYTE,
        port_write: 1'b0,
        port_wdata: `RST_WORD
    };

    dbg_pkg::core_state_t cur_ff;
    dbg_pkg::core_state_t nxt_ff;
    logic take_link;
    logic take_port;

    decode_if dif ();

    // Decoders always see the held select fields, never the request data
    assign dif.addr_bits = REQ_ADDR; // R1
    assign dif.link_bank = cur_ff.link_bank_field;
    assign dif.port_bank = cur_ff.port_bank_field;
    assign dif.port_selector = cur_ff.port_selector;

    link_register_decode u_link_dec (
        .dif(dif.link_dec)
    );

    port_register_decode #(
        .PORT_COUNT(PORTS)
    ) u_port_dec (
        .dif(dif.port_dec)
    );

    // Acknowledge of the port that holds the current transaction
    function automatic logic ack_of(
        input logic [PORT_COUNT-1:0] acks,
        input logic [7:0] sel
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < PORT_COUNT; i++) begin
            if (8'(i) == sel) begin
                hit = acks[i];
            end
        end
        return hit;
    endfunction

    // Read word of the port that holds the current transaction
    function automatic logic [31:0] data_of(
        input logic [PORT_COUNT*32-1:0] words,
        input logic [7:0] sel
    );
        logic [31:0] w;
        w = `RST_WORD;
        for (int i = 0; i < PORT_COUNT; i++) begin
            if (8'(i) == sel) begin
                w = words[i*32 +: 32];
            end
        end
        return w;
    endfunction

    // One debug port kind fixes the link for the whole unit; the word is
    // built from parameters alone, so it costs no flip-flops
    function automatic logic [31:0] config_word_of();
        logic [31:0] w;
        w = `RST_WORD;
        w[`CFG_PORTS_MSB:`CFG_PORTS_LSB] = 8'(PORTS); // R8
        w[`CFG_CHAINS_MSB:`CFG_CHAINS_LSB] = CHAINS; // R9
        w[`CFG_KIND_MSB:`CFG_KIND_LSB] = DEBUG_PORT_KIND; // R7
        w[`CFG_TAPS_MSB:`CFG_TAPS_LSB] = TAPS_PER_CHAIN; // R10
        return w;
    endfunction

    // Read-back image of the held select fields; other bits read zero
    function automatic logic [31:0] select_word_of(
        input dbg_pkg::core_state_t s
    );
        logic [31:0] w;
        w = `RST_WORD;
        w[`SEL_PORT_MSB:`SEL_PORT_LSB] = s.port_selector;
        w[`SEL_PBANK_MSB:`SEL_PBANK_LSB] = s.port_bank_field;
        w[`SEL_LBANK_MSB:`SEL_LBANK_LSB] = s.link_bank_field;
        return w;
    endfunction

    // Value each link register reads as; a write answers with the value
    // held before it, since the new one only lands at the next edge
    function automatic logic [31:0] link_read_data(
        input dbg_pkg::link_reg_t sel_reg,
        input dbg_pkg::core_state_t s
    );
        logic [31:0] w;
        w = `RST_WORD;
        case (sel_reg)
            dbg_pkg::LREG_ID: begin
                w = ID_VALUE;
            end
            dbg_pkg::LREG_CTRL: begin
                w = s.scratch;
            end
            dbg_pkg::LREG_SELECT: begin
                w = select_word_of(s);
            end
            dbg_pkg::LREG_RDBUF: begin
                w = s.read_buffer;
            end
            dbg_pkg::LREG_CONFIG: begin
                w = config_word_of();
            end
            default: begin
                w = `RST_WORD;
            end
        endcase
        return w;
    endfunction

    // Applies a link register write; only the control word and the
    // select fields take one
    function automatic dbg_pkg::core_state_t write_link(
        input dbg_pkg::core_state_t s,
        input dbg_pkg::link_reg_t sel_reg,
        input logic [31:0] wdata
    );
        dbg_pkg::core_state_t r;
        r = s;
        // Id, read buffer and configuration stay read-only
        if (sel_reg == dbg_pkg::LREG_CTRL) begin
            r.scratch = wdata; // R12
        end else if (sel_reg == dbg_pkg::LREG_SELECT) begin
            r.port_selector = wdata[`SEL_PORT_MSB:`SEL_PORT_LSB];
            r.port_bank_field = wdata[`SEL_PBANK_MSB:`SEL_PBANK_LSB];
            r.link_bank_field = wdata[`SEL_LBANK_MSB:`SEL_LBANK_LSB];
        end
        return r;
    endfunction

    // Launches a port transfer; selector and bank come from the held
    // select fields, never from the request, so they stay put between
    // port accesses and only the word bits change
    function automatic dbg_pkg::core_state_t issue_port(
        input dbg_pkg::core_state_t s,
        input logic [7:0] reg_addr,
        input logic wr,
        input logic [31:0] wdata
    );
        dbg_pkg::core_state_t r;
        r = s;
        r.port_req = 1'b1; // R3 R6
        r.port_sel = s.port_selector; // R3
        r.port_addr = reg_addr; // R4
        r.port_write = wr;
        r.port_wdata = wdata; // R12
        r.ready = 1'b0;
        r.state = dbg_pkg::ST_PORT_WAIT;
        return r;
    endfunction

    // Closes a port transfer; only a read refreshes the read buffer, so
    // a port write leaves the last read word in place
    function automatic dbg_pkg::core_state_t finish_port(
        input dbg_pkg::core_state_t s,
        input logic [31:0] word
    );
        dbg_pkg::core_state_t r;
        r = s;
        r.port_req = 1'b0;
        r.resp_valid = 1'b1;
        r.resp_fault = 1'b0;
        r.resp_rdata = `RST_WORD;
        if (!s.port_write) begin
            r.resp_rdata = word;
            r.read_buffer = word;
        end
        r.ready = 1'b1;
        r.state = dbg_pkg::ST_IDLE;
        return r;
    endfunction

    // Requests are taken only while ready and never queued, so one that
    // is offered while a port transfer is pending is not seen at all and
    // the link logic has to offer it again
    assign take_link = REQ_VALID && cur_ff.ready && !REQ_PORT;
    assign take_port = REQ_VALID && cur_ff.ready && REQ_PORT;

    // Response valid drops by default so each answer is a single pulse
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.resp_valid = 1'b0;
        case (cur_ff.state)
            dbg_pkg::ST_IDLE: begin
                if (take_link) begin
                    nxt_ff.resp_valid = 1'b1;
                    // A word that maps nothing in this bank answers with a fault
                    nxt_ff.resp_fault = (dif.link_reg == dbg_pkg::LREG_NONE);
                    nxt_ff.resp_rdata =
                        link_read_data(dif.link_reg, cur_ff); // R2
                    if (REQ_WRITE) begin
                        nxt_ff = write_link(nxt_ff, dif.link_reg, REQ_WDATA);
                    end
                end else if (take_port) begin
                    // The selector was checked against the built ports
                    if (dif.port_present) begin
                        nxt_ff = issue_port(nxt_ff, dif.port_reg_addr,
                            REQ_WRITE, REQ_WDATA); // R3
                    end else begin
                        // Reads as zero, so a debugger sees no known
                        // identity and skips the port
                        nxt_ff.resp_valid = 1'b1; // R15 R11
                        nxt_ff.resp_fault = 1'b0;
                        nxt_ff.resp_rdata = `RST_WORD;
                    end
                end
            end
            dbg_pkg::ST_PORT_WAIT: begin
                // No timeout: a port that never acknowledges stalls the
                // unit until reset
                if (ack_of(PORT_ACK, cur_ff.port_sel)) begin
                    nxt_ff = finish_port(nxt_ff,
                        data_of(PORT_RDATA, cur_ff.port_sel));
                end
            end
            default: begin
                nxt_ff = RST_STATE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cur_ff <= RST_STATE;
        end else if (CE) begin
            cur_ff <= nxt_ff;
        end
    end

    assign REQ_READY = cur_ff.ready;
    assign RESP_VALID = cur_ff.resp_valid;
    assign RESP_FAULT = cur_ff.resp_fault;
    assign RESP_RDATA = cur_ff.resp_rdata;
    assign PORT_REQ = cur_ff.port_req;
    assign PORT_SEL = cur_ff.port_sel;
    assign PORT_ADDR = cur_ff.port_addr; // R5
    assign PORT_WRITE = cur_ff.port_write;
    assign PORT_WDATA = cur_ff.port_wdata;
endmodule // debug_access_unit

// [dbg_consts.svh]
// Constants for register decoding of the debug access unit
`ifndef DBG_CONSTS_SVH
`define DBG_CONSTS_SVH

// Select register layout
`define SEL_PORT_MSB 31
`define SEL_PORT_LSB 24
`define SEL_PBANK_MSB 7
`define SEL_PBANK_LSB 4
`define SEL_LBANK_MSB 3
`define SEL_LBANK_LSB 0

// Word address bits inside a bank
`define ADDR_ID 2'h0
`define ADDR_CTRL 2'h1
`define ADDR_SELECT 2'h2
`define ADDR_RDBUF 2'h3
`define ADDR_CONFIG 2'h1

// Link register banks
`define LBANK_MAIN 4'h0
`define LBANK_CONFIG 4'h1

// Low address bits of every register address
`define WORD_ALIGN 2'h0

// Configuration word layout
`define CFG_PORTS_LSB 0
`define CFG_PORTS_MSB 7
`define CFG_CHAINS_LSB 8
`define CFG_CHAINS_MSB 11
`define CFG_KIND_LSB 12
`define CFG_KIND_MSB 13
`define CFG_TAPS_LSB 16
`define CFG_TAPS_MSB 19

// Structural limits
`define MAX_SCAN_CHAINS 4'h8
`define MIN_PORTS 9'h001

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0

`endif

// [dbg_pkg.sv]
// Types shared by the debug access unit and its decoders
package dbg_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_PORT_WAIT = 1'b1
    } state_t;

    typedef enum logic [2:0] {
        LREG_ID = 3'h0,
        LREG_CTRL = 3'h1,
        LREG_SELECT = 3'h3,
        LREG_RDBUF = 3'h2,
        LREG_CONFIG = 3'h6,
        LREG_NONE = 3'h7
    } link_reg_t;

    typedef enum logic [1:0] {
        KIND_SCAN = 2'h0,
        KIND_TWO_WIRE = 2'h1,
        KIND_DUAL = 2'h2
    } port_kind_t;

    typedef struct packed {
        state_t state;
        logic ready;
        logic [7:0] port_selector;
        logic [3:0] port_bank_field;
        logic [3:0] link_bank_field;
        logic [31:0] scratch;
        logic [31:0] read_buffer;
        logic resp_valid;
        logic resp_fault;
        logic [31:0] resp_rdata;
        logic port_req;
        logic [7:0] port_sel;
        logic [7:0] port_addr;
        logic port_write;
        logic [31:0] port_wdata;
    } core_state_t;

endpackage

// [decode_if.sv]
// Signals between the core and its two address decoders
interface decode_if;
    logic [1:0] addr_bits;
    logic [3:0] link_bank;
    logic [3:0] port_bank;
    logic [7:0] port_selector;
    dbg_pkg::link_reg_t link_reg;
    logic [7:0] port_reg_addr;
    logic port_present;

    modport core (
        output addr_bits,
        output link_bank,
        output port_bank,
        output port_selector,
        input link_reg,
        input port_reg_addr,
        input port_present
    );
    modport link_dec (
        input addr_bits,
        input link_bank,
        output link_reg
    );
    modport port_dec (
        input addr_bits,
        input port_bank,
        input port_selector,
        output port_reg_addr,
        output port_present
    );
endinterface

// [link_register_decode.sv]
// Picks a link register from the bank field and the word address
`include "dbg_consts.svh"

module link_register_decode (
    decode_if.link_dec dif
);
    function automatic dbg_pkg::link_reg_t pick(
        input logic [3:0] bank,
        input logic [1:0] addr
    );
        dbg_pkg::link_reg_t r;
        r = dbg_pkg::LREG_NONE;
        // Id, select and read buffer answer in every bank
        if (addr == `ADDR_ID) begin
            r = dbg_pkg::LREG_ID;
        end else if (addr == `ADDR_SELECT) begin
            r = dbg_pkg::LREG_SELECT;
        end else if (addr == `ADDR_RDBUF) begin
            r = dbg_pkg::LREG_RDBUF;
        end else if (bank == `LBANK_MAIN) begin
            r = dbg_pkg::LREG_CTRL;
        end else if (bank == `LBANK_CONFIG) begin
            r = dbg_pkg::LREG_CONFIG;
        end
        return r;
    endfunction

    assign dif.link_reg = pick(dif.link_bank, dif.addr_bits); // R2
endmodule // link_register_decode

// [port_register_decode.sv]
// Forms the access port register address and checks the port exists
`include "dbg_consts.svh"

module port_register_decode #(
    parameter int PORT_COUNT = 1
) (
    decode_if.port_dec dif
);
    localparam logic [8:0] COUNT = 9'(PORT_COUNT);

    // Bank above the word bits, low two bits always zero
    assign dif.port_reg_addr = {dif.port_bank, dif.addr_bits, `WORD_ALIGN}; // R4 R5 R3
    assign dif.port_present = {1'b0, dif.port_selector} < COUNT; // R15
endmodule // port_register_decode

// [access_unit_monitor.sv]
// Port-level checks on the debug access unit
module access_unit_monitor #(
    parameter int PORT_COUNT = 1
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic REQ_VALID,
    input wire logic REQ_PORT,
    input wire logic [1:0] REQ_ADDR,
    input wire logic REQ_WRITE,
    input wire logic [31:0] REQ_WDATA,
    input wire logic REQ_READY,
    input wire logic RESP_VALID,
    input wire logic RESP_FAULT,
    input wire logic [31:0] RESP_RDATA,
    input wire logic PORT_REQ,
    input wire logic [7:0] PORT_SEL,
    input wire logic [7:0] PORT_ADDR,
    input wire logic PORT_WRITE,
    input wire logic [31:0] PORT_WDATA,
    input wire logic [PORT_COUNT-1:0] PORT_ACK,
    input wire logic [PORT_COUNT*32-1:0] PORT_RDATA
);
    default clocking dc @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    wire logic take = CE && REQ_VALID && REQ_READY;
    wire logic hit = PORT_REQ && CE && PORT_ACK[PORT_SEL];
    wire logic [31:0] word = PORT_RDATA[PORT_SEL*32+:32];

    a_link_answer: assert property (
        take && !REQ_PORT |=> RESP_VALID) else $error("link not answered");
    a_port_addr: assert property (
        $rose(PORT_REQ) |-> PORT_ADDR[3:0] == {$past(REQ_ADDR), 2'h0})
        else $error("port address wrong");
    a_req_cause: assert property (
        $rose(PORT_REQ) |-> $past(take && REQ_PORT)
        && PORT_WRITE == $past(REQ_WRITE) && PORT_WDATA == $past(REQ_WDATA))
        else $error("port request without cause");
    a_fields_hold: assert property (
        PORT_REQ && $past(PORT_REQ) |-> $stable({PORT_SEL, PORT_ADDR}))
        else $error("port fields moved");
    a_align_zero: assert property (
        PORT_REQ |-> PORT_ADDR[1:0] == 2'h0) else $error("unaligned");
    a_ready_busy: assert property (
        PORT_REQ |-> !REQ_READY) else $error("ready while waiting");
    a_ack_done: assert property (
        hit && !PORT_WRITE |=> !PORT_REQ && RESP_VALID
        && RESP_RDATA == $past(word)) else $error("port read lost");
    a_ce_freeze: assert property (
        !CE |=> $stable({PORT_REQ, RESP_VALID, REQ_READY}))
        else $error("moved with enable low");

    c_link: cover property (take && !REQ_PORT);
    c_port: cover property (hit && !PORT_WRITE);
    c_freeze: cover property (!CE && REQ_VALID);
    c_fault: cover property (RESP_VALID && RESP_FAULT);
endmodule // access_unit_monitor

bind debug_access_unit access_unit_monitor #(.PORT_COUNT(PORT_COUNT)) mon (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .REQ_VALID(REQ_VALID),
    .REQ_PORT(REQ_PORT), .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE),
    .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RESP_VALID(RESP_VALID),
    .RESP_FAULT(RESP_FAULT), .RESP_RDATA(RESP_RDATA), .PORT_REQ(PORT_REQ),
    .PORT_SEL(PORT_SEL), .PORT_ADDR(PORT_ADDR), .PORT_WRITE(PORT_WRITE),
    .PORT_WDATA(PORT_WDATA), .PORT_ACK(PORT_ACK), .PORT_RDATA(PORT_RDATA));

// [port_model.sv]
// Behavioural access ports answering the unit's port requests
module port_model #(
    parameter int N = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic [7:0] sel,
    input wire logic [7:0] addr,
    input wire logic [1:0] dly,
    output logic [N-1:0] ack,
    output logic [N*32-1:0] rdata
);
    logic [3:0] cnt_ff;
    // Idle data toggles so a stale word never passes for a reply
    always_ff @(posedge clk) begin
        ack <= '0;
        rdata <= rst_n ? ~rdata : '0;
        if (!rst_n || !req) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == {2'h0, dly} && sel < 8'(N)) begin
                ack[sel] <= 1'b1;
                rdata[sel*32+:32] <= {sel, 8'h5A, 8'h00, addr};
            end
        end
    end
endmodule // port_model

// [debug_register_address_decode_tb.sv]
// Self-checking bench for the debug access unit decoding
module debug_register_address_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 2;
    localparam logic [31:0] ID = 32'h0000_2002; // Arbitrary value
    typedef struct packed {
        logic [2:0] f;
        logic [1:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;
    logic CORE_CLK, RST_N, CE, REQ_VALID, REQ_PORT, REQ_WRITE;
    logic REQ_READY, RESP_VALID, RESP_FAULT, PORT_REQ, PORT_WRITE;
    logic [1:0] REQ_ADDR, dly;
    logic [31:0] REQ_WDATA, RESP_RDATA, PORT_WDATA, q;
    logic [7:0] PORT_SEL, PORT_ADDR;
    logic [NP-1:0] PORT_ACK;
    logic [NP*32-1:0] PORT_RDATA;
    row_t rows [17];
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    debug_access_unit #(.PORT_COUNT(NP), .ID_VALUE(ID),
        .DEBUG_PORT_KIND(dbg_pkg::KIND_DUAL), .SCAN_CHAINS(4'hA),
        .TAPS_PER_CHAIN(4'h1)) DUT (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .REQ_VALID(REQ_VALID),
        .REQ_PORT(REQ_PORT), .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE),
        .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
        .RESP_VALID(RESP_VALID), .RESP_FAULT(RESP_FAULT),
        .RESP_RDATA(RESP_RDATA), .PORT_REQ(PORT_REQ), .PORT_SEL(PORT_SEL),
        .PORT_ADDR(PORT_ADDR), .PORT_WRITE(PORT_WRITE),
        .PORT_WDATA(PORT_WDATA), .PORT_ACK(PORT_ACK),
        .PORT_RDATA(PORT_RDATA));
    port_model #(.N(NP)) pm (.clk(CORE_CLK), .rst_n(RST_N), .req(PORT_REQ),
        .sel(PORT_SEL), .addr(PORT_ADDR), .dly(dly), .ack(PORT_ACK),
        .rdata(PORT_RDATA));

    function automatic logic [31:0] pw(input logic [7:0] s, a);
        return {s, 8'h5A, 8'h00, a};
    endfunction
    task automatic conclude;
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic drive(input logic [2:0] f, input logic [1:0] a,
                         input logic [31:0] d);
        REQ_VALID <= 1'b1;
        REQ_PORT <= f[2];
        REQ_WRITE <= f[1];
        REQ_ADDR <= a;
        REQ_WDATA <= d;
    endtask
    task automatic answer(input logic ef);
        int t;
        t = 0;
        #1;
        while (RESP_VALID !== 1'b1 && t < 40) begin
            @(posedge CORE_CLK);
            #1;
            t++;
        end
        chk({31'h0, RESP_VALID}, 32'h1);
        chk({31'h0, RESP_FAULT}, {31'h0, ef});
        q = RESP_RDATA;
    endtask
    task automatic xfer(input row_t r);
        @(posedge CORE_CLK);
        dly <= dly + 2'h1;
        drive(r.f, r.a, r.d);
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b0;
        answer(1'b0);
        if (r.f[0]) begin
            chk(q, r.e);
        end
    endtask

    initial begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        RST_N = 1'b0;
        CE = 1'b1;
        dly = 2'h0;
        // Idle request lines from time zero, so nothing is taken at release
        REQ_VALID = 1'b0;
        REQ_PORT = 1'b0;
        REQ_WRITE = 1'b0;
        REQ_ADDR = 2'h0;
        REQ_WDATA = 32'h0;
        // Flags: port, write, check
        rows = '{'{3'b001, 2'h0, 32'h0, ID},
            '{3'b011, 2'h2, 32'h0000_0010, 32'h0},
            '{3'b101, 2'h1, 32'h0, pw(8'h0, 8'h14)},
            '{3'b101, 2'h0, 32'h0, pw(8'h0, 8'h10)},
            '{3'b101, 2'h3, 32'h0, pw(8'h0, 8'h1C)},
            '{3'b001, 2'h3, 32'h0, pw(8'h0, 8'h1C)},
            '{3'b010, 2'h1, 32'hCAFE_F00D, 32'h0},
            '{3'b001, 2'h1, 32'h0, 32'hCAFE_F00D},
            '{3'b011, 2'h2, 32'h0100_0021, 32'h0000_0010},
            '{3'b001, 2'h1, 32'h0, 32'h0001_2802},
            '{3'b101, 2'h2, 32'h0, pw(8'h1, 8'h28)},
            '{3'b111, 2'h0, 32'h1234_5678, 32'h0},
            '{3'b001, 2'h3, 32'h0, pw(8'h1, 8'h28)},
            '{3'b011, 2'h2, 32'h05AA_AA00, 32'h0100_0021},
            '{3'b101, 2'h1, 32'h0, 32'h0},
            '{3'b001, 2'h3, 32'h0, pw(8'h1, 8'h28)},
            '{3'b001, 2'h2, 32'h0, 32'h0500_0000}};
        repeat (12) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        foreach (rows[i]) begin
            xfer(rows[i]);
        end
        // New select must steer a port access taken the very next cycle
        @(posedge CORE_CLK);
        drive(3'b010, 2'h2, 32'h0000_0030);
        @(posedge CORE_CLK);
        drive(3'b100, 2'h2, 32'h0);
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b0;
        answer(1'b0);
        chk(q, pw(8'h0, 8'h38));
        @(posedge CORE_CLK);
        CE <= 1'b0;
        drive(3'b000, 2'h0, 32'h0);
        repeat (3) @(posedge CORE_CLK);
        #1;
        chk({31'h0, RESP_VALID}, 32'h0);
        @(posedge CORE_CLK);
        CE <= 1'b1;
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b0;
        answer(1'b0);
        chk(q, ID);
        // Bank 2 maps nothing at word 1, so that answer must carry a fault
        xfer('{3'b010, 2'h2, 32'h0000_0002, 32'h0});
        @(posedge CORE_CLK);
        drive(3'b000, 2'h1, 32'h0);
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b0;
        answer(1'b1);
        // Mid-run reset must clear the select fields and both held words
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        #1;
        chk({31'h0, REQ_READY}, 32'h1);
        chk({31'h0, RESP_FAULT}, 32'h0);
        xfer('{3'b001, 2'h2, 32'h0, 32'h0});
        xfer('{3'b001, 2'h3, 32'h0, 32'h0});
        xfer('{3'b001, 2'h1, 32'h0, 32'h0});
        conclude();
    end
endmodule // debug_register_address_decode_tb
